// ---- pkg/atr_pkg.sv ----
// Package holding the register map, field layout and carriers of the converter control block.
// What this block does
// - Switch bit 17 enables and connects sensor.
// - Negative select forced zero during sensor conversion.
// - Start register at 0x0024 triggers a scan.
// - Channel enable register holds eight enable bits.
// - Working valid flags readable at 0x0200.
// - Result valid flags readable at 0x0204.
// - Two registers pack four sample-time values.
// - Shared range threshold and range condition registers.
// - Debug status register shows converter state.
// - Averaging status register shows scan progress.
// - Interrupt request, set and mask registers.
// - Eight result, config and working registers.
// - Masked view is request AND mask; drives interrupt.
package atr_pkg;

    // Byte offsets of the register map.
    localparam logic [11:0] OFS_GLOBAL_CONTROL = 12'h000;
    localparam logic [11:0] OFS_SAMPLE_CONTROL = 12'h004;
    localparam logic [11:0] OFS_SAMPLE_TIME_A = 12'h010;
    localparam logic [11:0] OFS_SAMPLE_TIME_B = 12'h014;
    localparam logic [11:0] OFS_RANGE_THRESHOLD = 12'h018;
    localparam logic [11:0] OFS_RANGE_CONDITION = 12'h01C;
    localparam logic [11:0] OFS_CHANNEL_ENABLE = 12'h020;
    localparam logic [11:0] OFS_START_TRIGGER = 12'h024;
    localparam logic [11:0] OFS_CONFIG_ARRAY = 12'h080;
    localparam logic [11:0] OFS_WORKING_ARRAY = 12'h100;
    localparam logic [11:0] OFS_RESULT_ARRAY = 12'h180;
    localparam logic [11:0] OFS_WORKING_VALID = 12'h200;
    localparam logic [11:0] OFS_RESULT_VALID = 12'h204;
    localparam logic [11:0] OFS_DEBUG_STATUS = 12'h208;
    localparam logic [11:0] OFS_AVERAGING_STATUS = 12'h20C;
    localparam logic [11:0] OFS_INTR_REQUEST = 12'h210;
    localparam logic [11:0] OFS_INTR_SET = 12'h214;
    localparam logic [11:0] OFS_INTR_MASK = 12'h218;
    localparam logic [11:0] OFS_INTR_MASKED = 12'h21C;
    localparam logic [11:0] OFS_FW_SWITCH = 12'h300;
    localparam logic [11:0] OFS_FW_SWITCH_CLEAR = 12'h304;
    localparam logic [11:0] OFS_SWITCH_HW_CTRL = 12'h340;
    localparam logic [11:0] OFS_SWITCH_STATUS = 12'h348;
    // Arrays occupy one 128-byte window each; address bits above bit 6 select the window.
    localparam int ARRAY_LSB = 7;

    // Field positions.
    localparam int CTRL_VREF_LSB = 4;
    localparam int CTRL_NEG_LSB = 9;
    localparam int CTRL_SWITCH_DISABLE = 30;
    localparam int CFG_PIN_LSB = 0;
    localparam int CFG_PORT_LSB = 4;
    localparam int CFG_DIFF_BIT = 8;
    localparam int SW_SENSOR_RETURN = 16;
    localparam int SW_SENSOR_POSITIVE = 17;
    localparam int START_FW_TRIGGER = 0;
    localparam int INTR_END_OF_SCAN = 0;
    localparam int INTR_OVERFLOW = 1;
    localparam int INTR_W = 2;
    localparam int STAT_BUSY_BIT = 31;

    // Sensor address on the sequencer channel map.
    localparam logic [2:0] SENSOR_PORT = 3'h7;
    localparam logic [2:0] SENSOR_PIN = 3'h0;
    localparam logic [2:0] NEGATIVE_INPUT_SELECT_SENSOR = 3'h0;
    localparam logic [31:0] SENSOR_SW_MASK = 32'h0003_0000;

    // Register bus request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } atr_bus_t;

    // Conversion request to the analog converter.
    typedef struct packed {
        logic req;
        logic [2:0] chan;
        logic [2:0] port;
        logic [2:0] pin;
        logic diff;
        logic [2:0] vref_sel;
        logic [2:0] negative_input_select;
    } atr_conv_t;

endpackage : atr_pkg

// ---- rtl/atr_regmap.sv ----
// Converter control: register map, channel scan sequencer and sensor switch routing.
`timescale 1ns/10ps
// Overview of operation.
// Software reaches every register over a
// plain strobe port with no wait states.
// A write takes effect at the clock edge
// that samples the write strobe.
// A read answer stands on the read data
// output for exactly one cycle.
// Outside that cycle the read data are zero.
// This keeps a stale answer from being
// mistaken for a fresh one by a careless master.
// Writes to read-only or unmapped words
// are ignored without any error signal.
// Unmapped reads return zero.
// There are no byte enables.
// Every access moves one whole word.
//
// Register groups.
// The global words hold control, sample
// control, two sample-time words, the range
// threshold, the range condition and the
// channel enable bits.
// The range words are stored only.
// No range comparison is made here.
// The sample-time words are stored only.
// The converter timing is not driven by them.
// The channel enable word keeps one bit per
// channel; upper bits read back as zero.
//
// Per-channel arrays.
// Configuration, working and result words
// each sit in their own window.
// A window is one power-of-two block of words.
// Words beyond the last channel read as zero.
// Working and result words keep the low
// data bits; the upper bits read as zero.
//
// Scan sequencer.
// A write of the trigger bit starts a scan
// when the sequencer is idle.
// The trigger is ignored when no channel
// is enabled, since there is nothing to do.
// A trigger during a scan is dropped.
// The dropped trigger raises a request bit
// so software can see that it was lost.
// Channels are visited in ascending order.
// Each visit issues one request pulse.
// The converter answers with one done pulse.
// There is no timeout on that answer.
// A converter that never answers holds the
// sequencer busy until reset.
// This is a known limitation of the design.
// Each answer fills the working word and
// marks it valid.
// After the last channel the valid working
// words are copied to the result words.
// The result valid flags take the working
// flags, and the working flags are cleared.
// The end-of-scan request is raised then.
// Results never change in mid-scan, so
// software may read them while a scan runs.
//
// Debug views.
// The debug status word shows the busy flag
// in its top bit and the current channel.
// The averaging status word counts the
// conversions finished in the present scan.
//
// Interrupts.
// Requests are sticky until software writes
// a one to clear them.
// A hardware event in the same cycle as a
// clear wins, so no event is ever lost.
// A write to the set word raises requests.
// The interrupt output follows the masked
// requests, changing at the same edge as they do.
//
// Sensor routing.
// Firmware switches are set by writing ones
// to one word and cleared through another.
// This avoids read-modify-write races.
// Sensor switches under hardware control close
// only while the scan visits a sensor channel;
// other hardware switches follow the firmware word.
// The global switch disable hands every
// switch back to the firmware word.
// The effective switch state is registered.
// It therefore lags its causes by one cycle.
// The sensor bias follows the positive
// switch of the sensor directly.
// The negative input select is forced to
// zero whenever that switch is closed.
// Software must still choose single-ended
// mode and the internal reference for the
// sensor; neither is enforced here.
//
// Reset.
// The asynchronous reset clears all state.
// All switches open and the sensor is
// unbiased until software acts.
// All outputs come straight from registers.
module atr_regmap
    import atr_pkg::*;
#(
    parameter int NUM_CH = 8,
    parameter int DATA_W = 12
) (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Register bus.
    input wire atr_bus_t i_bus,
    output logic [31:0] o_rdata,
    // Converter handshake.
    output atr_conv_t o_conv,
    input wire logic i_conv_done,
    input wire logic [DATA_W-1:0] i_conv_data,
    // Analog routing.
    output logic [31:0] o_switch,
    output logic o_sensor_enable,
    // Interrupt.
    output logic o_irq
);

    localparam int CH_W = 3;

    // The channel index and the array windows are three bits wide.
    if (NUM_CH < 1 || NUM_CH > 8 || DATA_W < 1 || DATA_W > 32) begin : g_bad_param
        $error("atr_regmap: NUM_CH must be 1..8 and DATA_W 1..32");
    end

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_REQ,
        SEQ_WAIT
    } atr_seq_t;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] sample_ctrl;
        logic [31:0] st_a;
        logic [31:0] st_b;
        logic [31:0] range_thres;
        logic [31:0] range_cond;
        logic [NUM_CH-1:0] chan_en;
        logic [NUM_CH-1:0][31:0] cfg;
        logic [NUM_CH-1:0][DATA_W-1:0] work;
        logic [NUM_CH-1:0][DATA_W-1:0] result;
        logic [NUM_CH-1:0] work_valid;
        logic [NUM_CH-1:0] result_valid;
        logic [INTR_W-1:0] intr;
        logic [INTR_W-1:0] intr_mask;
        logic [31:0] fw_switch;
        logic [31:0] hw_ctrl;
        logic [31:0] switch_eff;
        atr_seq_t seq;
        logic [CH_W-1:0] cur;
        logic [CH_W:0] done_cnt;
        logic [31:0] rdata;
        atr_conv_t conv;
        logic irq;
    } atr_state_t;

    atr_state_t state_q;
    atr_state_t state_d;

    // Lowest enabled channel at or above a start index; found flag in the top bit.
    function automatic logic [CH_W:0] next_chan(input logic [NUM_CH-1:0] en,
                                                input logic [CH_W:0] from);
        logic [CH_W:0] res;
        res = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (en[i] && i >= int'(from)) begin
                res = {1'b1, CH_W'(i)};
            end
        end
        return res;
    endfunction : next_chan

    // True when a channel configuration addresses the temperature sensor.
    function automatic logic is_sensor(input logic [31:0] cfg);
        return cfg[CFG_PORT_LSB +: 3] == SENSOR_PORT && cfg[CFG_PIN_LSB +: 3] == SENSOR_PIN;
    endfunction : is_sensor

    logic [CH_W:0] pick;
    logic [31:0] hw_mask;
    logic seq_sense;
    logic start_wr;
    logic [INTR_W-1:0] hw_set;
    logic [INTR_W-1:0] sw_set;
    logic [INTR_W-1:0] sw_clr;
    logic [CH_W-1:0] widx;
    logic [CH_W-1:0] ridx;
    logic [31:0] rd_val;
    logic [ARRAY_LSB-3-CH_W:0] word_hi;

    // Main next-state process: register writes, sequencer, routing, interrupts, read data.
    always_comb begin
        state_d = state_q;
        hw_set = '0;
        sw_set = '0;
        sw_clr = '0;
        pick = '0;
        rd_val = '0;
        word_hi = '0;
        widx = i_bus.addr[2 +: CH_W];
        ridx = i_bus.addr[2 +: CH_W];
        start_wr = i_bus.wr && i_bus.addr == OFS_START_TRIGGER && i_bus.wdata[START_FW_TRIGGER];

        // Plain register writes.
        if (i_bus.wr) begin
            case (i_bus.addr)
                OFS_GLOBAL_CONTROL: state_d.ctrl = i_bus.wdata;
                OFS_SAMPLE_CONTROL: state_d.sample_ctrl = i_bus.wdata;
                OFS_SAMPLE_TIME_A: state_d.st_a = i_bus.wdata;
                OFS_SAMPLE_TIME_B: state_d.st_b = i_bus.wdata;
                OFS_RANGE_THRESHOLD: state_d.range_thres = i_bus.wdata;
                OFS_RANGE_CONDITION: state_d.range_cond = i_bus.wdata;
                OFS_CHANNEL_ENABLE: state_d.chan_en = i_bus.wdata[NUM_CH-1:0];
                OFS_INTR_REQUEST: sw_clr = i_bus.wdata[INTR_W-1:0];
                OFS_INTR_SET: sw_set = i_bus.wdata[INTR_W-1:0];
                OFS_INTR_MASK: state_d.intr_mask = i_bus.wdata[INTR_W-1:0];
                OFS_FW_SWITCH: state_d.fw_switch = state_q.fw_switch | i_bus.wdata;
                OFS_FW_SWITCH_CLEAR: state_d.fw_switch = state_q.fw_switch & ~i_bus.wdata;
                OFS_SWITCH_HW_CTRL: state_d.hw_ctrl = i_bus.wdata;
                default: begin
                    if (i_bus.addr[11:ARRAY_LSB] == OFS_CONFIG_ARRAY[11:ARRAY_LSB]
                        && int'(widx) < NUM_CH && i_bus.addr[ARRAY_LSB-1:2+CH_W] == '0) begin
                        state_d.cfg[widx] = i_bus.wdata;
                    end
                end
            endcase
        end

        // Scan sequencer; the converter answers each request with one done pulse.
        state_d.conv.req = 1'b0;
        case (state_q.seq)
            SEQ_IDLE: begin
                pick = next_chan(state_q.chan_en, '0);
                if (start_wr && pick[CH_W]) begin
                    state_d.cur = pick[CH_W-1:0];
                    state_d.done_cnt = '0;
                    state_d.seq = SEQ_REQ;
                end
            end
            SEQ_REQ: begin
                state_d.conv.req = 1'b1;
                state_d.conv.chan = state_q.cur;
                state_d.conv.port = state_q.cfg[state_q.cur][CFG_PORT_LSB +: 3];
                state_d.conv.pin = state_q.cfg[state_q.cur][CFG_PIN_LSB +: 3];
                state_d.conv.diff = state_q.cfg[state_q.cur][CFG_DIFF_BIT];
                state_d.conv.vref_sel = state_q.ctrl[CTRL_VREF_LSB +: 3];
                state_d.seq = SEQ_WAIT;
            end
            SEQ_WAIT: begin
                if (i_conv_done) begin
                    state_d.work[state_q.cur] = i_conv_data;
                    state_d.work_valid[state_q.cur] = 1'b1;
                    state_d.done_cnt = state_q.done_cnt + 1'b1;
                    pick = next_chan(state_q.chan_en, {1'b0, state_q.cur} + 1'b1);
                    if (pick[CH_W]) begin
                        state_d.cur = pick[CH_W-1:0];
                        state_d.seq = SEQ_REQ;
                    end else begin
                        for (int i = 0; i < NUM_CH; i++) begin
                            if (state_d.work_valid[i]) begin
                                state_d.result[i] = state_d.work[i];
                            end
                        end
                        state_d.result_valid = state_d.work_valid;
                        state_d.work_valid = '0;
                        hw_set[INTR_END_OF_SCAN] = 1'b1;
                        state_d.seq = SEQ_IDLE;
                    end
                end
            end
            default: state_d.seq = SEQ_IDLE;
        endcase
        // A trigger while a scan runs is dropped and flagged.
        if (start_wr && state_q.seq != SEQ_IDLE) begin
            hw_set[INTR_OVERFLOW] = 1'b1;
        end

        state_d.intr = (state_q.intr & ~sw_clr) | hw_set | sw_set;
        state_d.irq = |(state_d.intr & state_d.intr_mask);

        seq_sense = state_q.seq != SEQ_IDLE && is_sensor(state_q.cfg[state_q.cur]);
        hw_mask = state_q.hw_ctrl & ~{32{state_q.ctrl[CTRL_SWITCH_DISABLE]}};
        state_d.switch_eff = (state_q.fw_switch & ~hw_mask)
            | (hw_mask & SENSOR_SW_MASK & {32{seq_sense}})
            | (hw_mask & ~SENSOR_SW_MASK & state_q.fw_switch);
        state_d.conv.negative_input_select = state_d.switch_eff[SW_SENSOR_POSITIVE]
            ? NEGATIVE_INPUT_SELECT_SENSOR : state_q.ctrl[CTRL_NEG_LSB +: 3];

        // Read decode; the answer stands for the single cycle after the strobe.
        if (i_bus.rd) begin
            case (i_bus.addr)
                OFS_GLOBAL_CONTROL: rd_val = state_q.ctrl;
                OFS_SAMPLE_CONTROL: rd_val = state_q.sample_ctrl;
                OFS_SAMPLE_TIME_A: rd_val = state_q.st_a;
                OFS_SAMPLE_TIME_B: rd_val = state_q.st_b;
                OFS_RANGE_THRESHOLD: rd_val = state_q.range_thres;
                OFS_RANGE_CONDITION: rd_val = state_q.range_cond;
                OFS_CHANNEL_ENABLE: rd_val = 32'(state_q.chan_en);
                OFS_WORKING_VALID: rd_val = 32'(state_q.work_valid);
                OFS_RESULT_VALID: rd_val = 32'(state_q.result_valid);
                OFS_DEBUG_STATUS: begin
                    rd_val[STAT_BUSY_BIT] = state_q.seq != SEQ_IDLE;
                    rd_val[CH_W-1:0] = state_q.cur;
                end
                OFS_AVERAGING_STATUS: rd_val = 32'(state_q.done_cnt);
                OFS_INTR_REQUEST: rd_val = 32'(state_q.intr);
                OFS_INTR_MASK: rd_val = 32'(state_q.intr_mask);
                OFS_INTR_MASKED: rd_val = 32'(state_q.intr & state_q.intr_mask);
                OFS_FW_SWITCH: rd_val = state_q.fw_switch;
                OFS_SWITCH_HW_CTRL: rd_val = state_q.hw_ctrl;
                OFS_SWITCH_STATUS: rd_val = state_q.switch_eff;
                default: begin
                    word_hi = i_bus.addr[ARRAY_LSB-1:2+CH_W];
                    if (int'(ridx) < NUM_CH && word_hi == '0) begin
                        case (i_bus.addr[11:ARRAY_LSB])
                            OFS_CONFIG_ARRAY[11:ARRAY_LSB]: rd_val = state_q.cfg[ridx];
                            OFS_WORKING_ARRAY[11:ARRAY_LSB]: rd_val = 32'(state_q.work[ridx]);
                            OFS_RESULT_ARRAY[11:ARRAY_LSB]: rd_val = 32'(state_q.result[ridx]);
                            default: rd_val = '0;
                        endcase
                    end
                end
            endcase
        end
        state_d.rdata = rd_val;
    end

    // Every piece of state lives in one register; reset clears it all, switches open.
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs straight from the state register.
    assign o_rdata = state_q.rdata;
    assign o_conv = state_q.conv;
    assign o_switch = state_q.switch_eff;
    assign o_sensor_enable = state_q.switch_eff[SW_SENSOR_POSITIVE];
    assign o_irq = state_q.irq;

endmodule : atr_regmap

// ---- testbench/atr_conv_model.sv ----
// Behavioural converter with sensor multiplexer, answering conversion requests.
`timescale 1ns/10ps
module atr_conv_model
    import atr_pkg::*;
(
    // Clock and request.
    input wire logic i_core_clk,
    input wire atr_conv_t i_conv,
    input wire logic i_sensor_enable,
    input wire logic i_slow,
    // Answer.
    output logic o_done,
    output logic [11:0] o_data
);
    int cnt = 0;
    logic [11:0] val = 12'h000;
    initial o_done = 1'b0;
    initial o_data = 12'h000;
    // Data stand only with the answer pulse; otherwise the inverse shows, never a held value.
    always @(posedge i_core_clk) begin
        if (i_conv.req) cnt = i_slow ? 9 : 3;
        else if (cnt > 0) cnt = cnt - 1;
        if (cnt == 1) begin
            val = (i_sensor_enable && i_conv.port == SENSOR_PORT) ? 12'h7E0
                : 12'h5A0 + {9'h0, i_conv.chan};
            o_done <= 1'b1;
            o_data <= val;
        end else begin
            o_done <= 1'b0;
            o_data <= ~val;
        end
    end
endmodule : atr_conv_model

// ---- testbench/atr_regmap_monitor.sv ----
// Port checker of the converter control block.
`timescale 1ns/10ps
module atr_regmap_monitor
    import atr_pkg::*;
#(
    parameter int DATA_W = 12
) (
    // Clock, reset and bus.
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire atr_bus_t i_bus,
    input wire logic [31:0] o_rdata,
    // Converter, routing and interrupt.
    input wire atr_conv_t o_conv,
    input wire logic i_conv_done,
    input wire logic [DATA_W-1:0] i_conv_data,
    input wire logic [31:0] o_switch,
    input wire logic o_sensor_enable,
    input wire logic o_irq
);
    logic [1:0] mask_q;
    logic pend_q;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    // Shadow the mask and an open conversion, since neither is visible at the ports.
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mask_q <= 2'h0;
            pend_q <= 1'b0;
        end else begin
            if (i_bus.wr && i_bus.addr == OFS_INTR_MASK) mask_q <= i_bus.wdata[1:0];
            if (o_conv.req) pend_q <= 1'b1;
            else if (i_conv_done) pend_q <= 1'b0;
        end
    end
    sensor_follow_a: assert property (o_sensor_enable == o_switch[SW_SENSOR_POSITIVE])
        else $error("sensor enable differs from switch bit");
    neg_zero_a: assert property (o_sensor_enable |-> o_conv.negative_input_select == NEGATIVE_INPUT_SELECT_SENSOR)
        else $error("negative select not zero for sensor");
    req_pulse_a: assert property (o_conv.req |=> !o_conv.req)
        else $error("conversion request longer than one cycle");
    conv_hold_a: assert property (!o_conv.req |-> $stable({o_conv.chan, o_conv.port}))
        else $error("conversion address moved without request");
    rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
        else $error("read data outside read answer");
    switch_read_a: assert property (i_bus.rd && i_bus.addr == OFS_SWITCH_STATUS
        |=> o_rdata == $past(o_switch)) else $error("switch status read wrong");
    busy_read_a: assert property (i_bus.rd && i_bus.addr == OFS_DEBUG_STATUS && pend_q
        |=> o_rdata[STAT_BUSY_BIT] && o_rdata[2:0] == $past(o_conv.chan))
        else $error("debug status wrong while converting");
    set_raise_a: assert property (i_bus.wr && i_bus.addr == OFS_INTR_SET
        && (i_bus.wdata[1:0] & mask_q) != 2'h0 |-> ##[1:2] o_irq)
        else $error("set request did not raise interrupt");
    mask_quiet_a: assert property (mask_q == 2'h0 && $past(mask_q) == 2'h0 |-> !o_irq)
        else $error("interrupt high with all masked");
endmodule : atr_regmap_monitor

bind atr_regmap atr_regmap_monitor #(.DATA_W(DATA_W)) u_atr_regmap_monitor (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_bus(i_bus), .o_rdata(o_rdata),
    .o_conv(o_conv), .i_conv_done(i_conv_done), .i_conv_data(i_conv_data),
    .o_switch(o_switch), .o_sensor_enable(o_sensor_enable), .o_irq(o_irq));

// ---- testbench/atr_regmap_tb.sv ----
// Self-checking bench of the converter control block.
`timescale 1ns/10ps
module atr_regmap_tb import atr_pkg::*; ();
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    atr_bus_t i_bus = '0;
    logic [31:0] o_rdata, o_switch, rnd;
    atr_conv_t o_conv;
    logic i_conv_done, o_sensor_enable, o_irq, sens_seen;
    logic slow = 1'b1;
    logic rd_seen = 1'b0;
    logic [11:0] i_conv_data;
    logic [31:0] exp_q[$], msk_q[$];
    int error_cnt = 0;
    int n_checks = 0;
    integer seed = 32'hf48a;
    logic [11:0] ofs[6] = '{OFS_SAMPLE_CONTROL, OFS_SAMPLE_TIME_A, OFS_SAMPLE_TIME_B,
        OFS_RANGE_THRESHOLD, OFS_RANGE_CONDITION, OFS_CHANNEL_ENABLE};
    logic [31:0] msk[6] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
        32'hFFFF_FFFF, 32'h0000_00FF};
    always #4 i_core_clk = ~i_core_clk;
    atr_regmap u_atr_regmap (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_bus(i_bus),
        .o_rdata(o_rdata), .o_conv(o_conv), .i_conv_done(i_conv_done),
        .i_conv_data(i_conv_data), .o_switch(o_switch), .o_sensor_enable(o_sensor_enable),
        .o_irq(o_irq));
    atr_conv_model u_atr_conv_model (.i_core_clk(i_core_clk), .i_conv(o_conv),
        .i_sensor_enable(o_sensor_enable), .i_slow(slow), .o_done(i_conv_done),
        .o_data(i_conv_data));
    task automatic check(input string w, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, s);
        end
    endtask : check
    // Read answers arrive one cycle late, so they are matched against queued notes.
    always @(posedge i_core_clk) rd_seen <= i_bus.rd;
    always @(negedge i_core_clk) begin
        if (rd_seen) check("read data", exp_q.pop_front(), o_rdata & msk_q.pop_front());
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_core_clk);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge i_core_clk);
    endtask : rd
    task automatic idle(input int n);
        i_bus <= '0;
        repeat (n) @(posedge i_core_clk);
    endtask : idle
    task automatic lvl(input string w, input logic e, ref logic s);
        @(negedge i_core_clk);
        check(w, {31'h0, e}, {31'h0, s});
        @(posedge i_core_clk);
    endtask : lvl
    // Bounded wait for the end-of-scan interrupt, noting any sensor connection.
    task automatic wait_irq();
        sens_seen = 1'b0;
        for (int i = 0; i < 300 && o_irq !== 1'b1; i++) begin
            @(negedge i_core_clk);
            sens_seen = sens_seen | o_sensor_enable;
        end
        check("scan end irq", 32'h1, {31'h0, o_irq});
        @(posedge i_core_clk);
    endtask : wait_irq
    task automatic results();
        if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    initial begin
        #200000;
        error_cnt++;
        results();
    end
    initial begin
        repeat (12) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        idle(1);
        rd(OFS_INTR_REQUEST, 32'h0, 32'hFFFF_FFFF);
        rd(12'h0FC, 32'h0, 32'hFFFF_FFFF);
        // Random round trip through the stored registers.
        for (int i = 0; i < 6; i++) begin
            rnd = $random(seed);
            wr(ofs[i], rnd);
            rd(ofs[i], rnd, msk[i]);
        end
        wr(OFS_RESULT_VALID, rnd);
        rd(OFS_RESULT_VALID, 32'h0, 32'hFFFF_FFFF);
        wr(OFS_RESULT_ARRAY, rnd);
        rd(OFS_RESULT_ARRAY, 32'h0, 32'hFFFF_FFFF);
        wr(OFS_INTR_MASK, 32'h3);
        wr(OFS_INTR_SET, 32'h1);
        idle(2);
        lvl("irq set", 1'b1, o_irq);
        rd(OFS_INTR_MASKED, 32'h1, 32'h3);
        wr(OFS_INTR_MASK, 32'h2);
        idle(2);
        lvl("irq masked", 1'b0, o_irq);
        wr(OFS_INTR_REQUEST, 32'h1);
        rd(OFS_INTR_REQUEST, 32'h0, 32'h3);
        wr(OFS_INTR_MASK, 32'h1);
        // Sequencer routing with the sensor on channel 0, single-ended, reference 0.
        wr(OFS_GLOBAL_CONTROL, 32'h0000_0600);
        wr(OFS_CONFIG_ARRAY, 32'h0000_0070);
        wr(OFS_CONFIG_ARRAY + 12'h8, 32'h0000_0013);
        wr(OFS_SWITCH_HW_CTRL, SENSOR_SW_MASK);
        wr(OFS_FW_SWITCH, SENSOR_SW_MASK);
        wr(OFS_CHANNEL_ENABLE, 32'h5);
        wr(OFS_START_TRIGGER, 32'h1);
        wr(OFS_START_TRIGGER, 32'h1);
        idle(2);
        rd(OFS_DEBUG_STATUS, 32'h8000_0000, 32'h8000_0007);
        idle(1);
        wait_irq();
        lvl("sensor in scan", 1'b1, sens_seen);
        lvl("sensor after scan", 1'b0, o_sensor_enable);
        rd(OFS_RESULT_ARRAY, 32'h7E0, 32'hFFF);
        rd(OFS_RESULT_ARRAY + 12'h8, 32'h5A2, 32'hFFF);
        rd(OFS_RESULT_VALID, 32'h5, 32'hFF);
        rd(OFS_WORKING_VALID, 32'h0, 32'hFF);
        rd(OFS_INTR_REQUEST, 32'h3, 32'h3);
        wr(OFS_INTR_REQUEST, 32'h3);
        // Prompt converter on the last channel alone.
        slow <= 1'b0;
        wr(OFS_CHANNEL_ENABLE, 32'h80);
        wr(OFS_START_TRIGGER, 32'h1);
        idle(1);
        wait_irq();
        rd(OFS_RESULT_ARRAY + 12'h1C, 32'h5A7, 32'hFFF);
        rd(OFS_RESULT_VALID, 32'h80, 32'hFF);
        // Firmware routing: global switch disable, hardware control dropped.
        wr(OFS_GLOBAL_CONTROL, 32'h4000_0600);
        wr(OFS_SWITCH_HW_CTRL, 32'h0);
        idle(3);
        lvl("firmware sensor on", 1'b1, o_sensor_enable);
        wr(OFS_FW_SWITCH_CLEAR, 32'h0002_0000);
        idle(3);
        lvl("firmware sensor off", 1'b0, o_sensor_enable);
        rd(OFS_SWITCH_STATUS, 32'h0001_0000, 32'h0003_0000);
        idle(3);
        results();
    end
endmodule : atr_regmap_tb
